// ### core/uhp_cmd.sv
`include "uhp_params.svh"

module uhp_cmd import uhp_pkg::*; (
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic RX_VALID_I,
	input wire logic [7:0] RX_DATA_I,
	output logic RX_READY_O,
	output logic TX_VALID_O,
	output logic [7:0] TX_DATA_O,
	input wire logic TX_READY_I,
	input wire logic [4:0] LOW_PINS_GPIO_I,
	output uhp_desig_t PIN_DESIG_O,
	output logic [7:0] DEFAULT_OUT_O,
	output logic [7:0] DEFAULT_DIR_O,
	output logic [7:0] CURRENT_DIR_O,
	output uhp_misc_t MISC_O,
	output logic CMD_DONE_O
);

	// Sequencer and report bookkeeping
	uhp_state_t state; // Sequencer state
	logic [5:0] idx; // Byte counter inside a report
	logic [7:0] shadow [0:17]; // Meaningful head of the command report
	logic [7:0] rsp_cmd; // Command code echoed in the response
	logic [7:0] rsp_sts; // Status of the command in progress

	// Accept handshake on the receive side
	wire rx_take = RX_VALID_I && RX_READY_O;
	// Byte handed to the host on this edge
	wire tx_take = TX_VALID_O && TX_READY_I;
	// Last byte of a 64-byte report, in either direction
	wire rx_last = idx == `UHP_LAST_IDX;
	// Bytes past the shadow are reserved and dropped
	wire rx_keep = idx <= {1'b0, `UHP_SHADOW_LAST};

	// Command decode on the stored code byte
	wire [7:0] cmd = shadow[`UHP_IDX_CMD];
	wire is_set = cmd == `UHP_CMD_SET_SETTINGS;
	wire is_sdir = cmd == `UHP_CMD_SET_DIR;
	wire is_gdir = cmd == `UHP_CMD_GET_DIR;
	// Unknown codes are echoed with a failure status and change nothing
	wire known = is_set || is_sdir || is_gdir;

	// Function codes: out-of-range values leave the pin as it was
	wire d5_ok = shadow[`UHP_IDX_DESIG5] <= `UHP_DESIG_MAX;
	wire d6_ok = shadow[`UHP_IDX_DESIG6] <= `UHP_DESIG_MAX;
	wire d7_ok = shadow[`UHP_IDX_DESIG7] <= `UHP_DESIG_MAX;
	// Input-only pin takes input or dedicated, never chip select
	wire d8_ok = (shadow[`UHP_IDX_DESIG8] == `UHP_DESIG_GPIO)
		|| (shadow[`UHP_IDX_DESIG8] == `UHP_DESIG_DEDICATED);

	// Rejected codes fall back to the stored function
	wire [1:0] next_d5 = d5_ok ? shadow[`UHP_IDX_DESIG5][1:0] : PIN_DESIG_O.general_pin_5;
	wire [1:0] next_d6 = d6_ok ? shadow[`UHP_IDX_DESIG6][1:0] : PIN_DESIG_O.general_pin_6;
	wire [1:0] next_d7 = d7_ok ? shadow[`UHP_IDX_DESIG7][1:0] : PIN_DESIG_O.general_pin_7;
	wire [1:0] next_d8 = d8_ok ? shadow[`UHP_IDX_DESIG8][1:0] : PIN_DESIG_O.input_only_pin;

	// Other-settings byte split into its fields; bits 7:5 unused
	wire [7:0] other = shadow[`UHP_IDX_OTHER];
	wire [2:0] cnt_code = other[`UHP_BIT_CNT_HI:`UHP_BIT_CNT_LO];
	// Reserved counting codes keep the previous mode
	wire cnt_ok = cnt_code <= UHP_CNT_HIGH;
	uhp_misc_t next_misc;
	// One assignment in struct order: wake, counting mode, bus hold
	assign next_misc = {other[`UHP_BIT_WAKE],
		cnt_ok ? cnt_code : MISC_O.count_mode,
		other[`UHP_BIT_SPI_HOLD]};

	// Two-bit form of the GPIO function code, as stored per pin
	wire [1:0] desig_gpio = 2'(`UHP_DESIG_GPIO);
	// Pins that are GPIO after this command: pins 5 to 7 from the new functions, low pins from LOW_PINS_GPIO_I
	wire [7:0] gpio_mask_new = {next_d7 == desig_gpio,
		next_d6 == desig_gpio, next_d5 == desig_gpio, LOW_PINS_GPIO_I};
	// Pins that are GPIO now
	wire [7:0] gpio_mask = {PIN_DESIG_O.general_pin_7 == desig_gpio,
		PIN_DESIG_O.general_pin_6 == desig_gpio,
		PIN_DESIG_O.general_pin_5 == desig_gpio, LOW_PINS_GPIO_I};

	// Direction update restricted to GPIO pins
	wire [7:0] set_dir_word = shadow[`UHP_IDX_DIR_LO];
	wire [7:0] next_dir_sdir = (CURRENT_DIR_O & ~gpio_mask)
		| (set_dir_word & gpio_mask);
	// New settings load the default direction into GPIO pins
	wire [7:0] next_dir_set = (CURRENT_DIR_O & ~gpio_mask_new)
		| (shadow[`UHP_IDX_DEF_DIR] & gpio_mask_new);

	// Index of the next response byte to place on the output
	wire [5:0] rsp_idx = (state == UHP_APPLY) ? `UHP_RSP_CMD : idx + 6'h01;
	// Response byte selection; unused bytes read as zero
	wire [7:0] rsp_byte = (rsp_idx == `UHP_RSP_CMD) ? rsp_cmd
		: (rsp_idx == `UHP_RSP_STS) ? rsp_sts
		: (is_gdir && rsp_idx == `UHP_RSP_DIR_LO) ? CURRENT_DIR_O
		: (is_gdir && rsp_idx == `UHP_RSP_DIR_HI) ? `UHP_DIR_HI_RSP
		: `UHP_RST_BYTE;

	// Sequencer: a whole report in, then a whole report out
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			state <= UHP_RECV;
		end else begin
			case (state)
				// Leave receive only after the 64th byte
				UHP_RECV: begin
					if (rx_take && rx_last) begin
						state <= UHP_APPLY;
					end
				end
				UHP_APPLY: begin
					state <= UHP_SEND;
				end
				// Next command waits until the last response byte leaves
				UHP_SEND: begin
					if (tx_take && rx_last) begin
						state <= UHP_RECV;
					end
				end
				default: begin
					state <= UHP_RECV;
				end
			endcase
		end
	end

	// Byte counter shared by both directions
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			idx <= 6'h00;
		end else if (rx_take || tx_take) begin
			idx <= idx + 6'h01;
		end else if (state == UHP_APPLY) begin
			idx <= 6'h00;
		end
	end

	// Capture of the meaningful command bytes; zero fill is not checked
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			for (int i = 0; i < 18; i++) begin
				shadow[i] <= `UHP_RST_BYTE;
			end
		end else if (rx_take && rx_keep) begin
			shadow[idx[4:0]] <= RX_DATA_I;
		end
	end

	// Receive ready drops once a full report is in
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			RX_READY_O <= 1'b1;
		end else if (rx_take && rx_last) begin
			RX_READY_O <= 1'b0;
		end else if (tx_take && rx_last) begin
			RX_READY_O <= 1'b1;
		end
	end

	// Echo and status latched as the last command byte is taken
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			rsp_cmd <= `UHP_RST_BYTE;
			rsp_sts <= `UHP_STS_OK;
		end else if (state == UHP_RECV && rx_take && rx_last) begin
			// The code byte has sat in the shadow since byte 0 arrived
			rsp_cmd <= cmd;
			rsp_sts <= known ? `UHP_STS_OK : `UHP_STS_UNSUPPORTED;
		end
	end

	// Response stream; a stalled host holds the byte in place
	// Byte 0 is loaded on leaving APPLY, later bytes follow each take
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			TX_VALID_O <= 1'b0;
			TX_DATA_O <= `UHP_RST_BYTE;
		end else if (state == UHP_APPLY) begin
			TX_VALID_O <= 1'b1;
			TX_DATA_O <= rsp_byte;
		end else if (tx_take && rx_last) begin
			TX_VALID_O <= 1'b0;
			TX_DATA_O <= `UHP_RST_BYTE;
		end else if (tx_take) begin
			TX_DATA_O <= rsp_byte;
		end
	end

	// Volatile settings, taken only from a set-current-settings report
	// Bytes 14 and 16 are not stored: their high halves carry nothing here
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			PIN_DESIG_O <= {4{`UHP_RST_DESIG}};
			DEFAULT_OUT_O <= `UHP_RST_BYTE;
			DEFAULT_DIR_O <= `UHP_RST_DIR;
			MISC_O <= '0;
		end else if (state == UHP_APPLY && is_set) begin
			PIN_DESIG_O <= {next_d7, next_d6, next_d5, next_d8};
			DEFAULT_OUT_O <= shadow[`UHP_IDX_DEF_OUT];
			DEFAULT_DIR_O <= shadow[`UHP_IDX_DEF_DIR];
			MISC_O <= next_misc;
		end
	end

	// Current direction word; the high byte is implied by the input-only pin
	// A settings report reloads GPIO pins from the default direction
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			CURRENT_DIR_O <= `UHP_RST_DIR;
		end else if (state == UHP_APPLY && is_sdir) begin
			CURRENT_DIR_O <= next_dir_sdir;
		end else if (state == UHP_APPLY && is_set) begin
			CURRENT_DIR_O <= next_dir_set;
		end
	end

	// One-cycle pulse when a command takes effect
	// Rises on the same edge as the first response byte
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			CMD_DONE_O <= 1'b0;
		end else begin
			CMD_DONE_O <= state == UHP_APPLY;
		end
	end

endmodule : uhp_cmd

// ### core/uhp_params.svh
`ifndef UHP_PARAMS_SVH
`define UHP_PARAMS_SVH

// Report framing
`define UHP_LAST_IDX 6'h3F
`define UHP_SHADOW_LAST 5'h11

// Command codes
`define UHP_CMD_SET_SETTINGS 8'h21
`define UHP_CMD_SET_DIR 8'h32
`define UHP_CMD_GET_DIR 8'h33

// Status codes
`define UHP_STS_OK 8'h00
`define UHP_STS_UNSUPPORTED 8'hF8

// Byte positions inside a command report
`define UHP_IDX_CMD 5'h00
`define UHP_IDX_DIR_LO 5'h04
`define UHP_IDX_DIR_HI 5'h05
`define UHP_IDX_DESIG5 5'h09
`define UHP_IDX_DESIG6 5'h0A
`define UHP_IDX_DESIG7 5'h0B
`define UHP_IDX_DESIG8 5'h0C
`define UHP_IDX_DEF_OUT 5'h0D
`define UHP_IDX_DEF_DIR 5'h0F
`define UHP_IDX_OTHER 5'h11

// Byte positions inside a response report
`define UHP_RSP_CMD 6'h00
`define UHP_RSP_STS 6'h01
`define UHP_RSP_DIR_LO 6'h04
`define UHP_RSP_DIR_HI 6'h05

// Field positions in the other-settings byte
`define UHP_BIT_WAKE 4
`define UHP_BIT_CNT_HI 3
`define UHP_BIT_CNT_LO 1
`define UHP_BIT_SPI_HOLD 0

// Function codes
`define UHP_DESIG_GPIO 8'h00
`define UHP_DESIG_CS 8'h01
`define UHP_DESIG_DEDICATED 8'h02
`define UHP_DESIG_MAX 8'h02

// Reset values and the fixed high direction response byte
`define UHP_RST_DESIG 2'h0
`define UHP_RST_BYTE 8'h00
`define UHP_RST_DIR 8'hFF
`define UHP_DIR_HI_RSP 8'h01

`endif

// ### core/uhp_pkg.sv
package uhp_pkg;

	// Command sequencer states
	typedef enum logic [1:0] {
		UHP_RECV = 2'b00,
		UHP_APPLY = 2'b01,
		UHP_SEND = 2'b10
	} uhp_state_t;

	// Interrupt-pin counting modes
	typedef enum logic [2:0] {
		UHP_CNT_OFF = 3'b000,
		UHP_CNT_FALL = 3'b001,
		UHP_CNT_RISE = 3'b010,
		UHP_CNT_LOW = 3'b011,
		UHP_CNT_HIGH = 3'b100
	} uhp_count_t;

	// Other chip settings carried together
	typedef struct packed {
		logic remote_wake;
		logic [2:0] count_mode;
		logic spi_hold;
	} uhp_misc_t;

	// Function of general pins 5 to 7 and the input-only pin
	typedef struct packed {
		logic [1:0] general_pin_7;
		logic [1:0] general_pin_6;
		logic [1:0] general_pin_5;
		logic [1:0] input_only_pin;
	} uhp_desig_t;

endpackage : uhp_pkg

// ### verification/uhp_cmd_assertions.sv
module uhp_cmd_assertions import uhp_pkg::*; (
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic RX_VALID_I,
	input wire logic RX_READY_O,
	input wire logic TX_VALID_O,
	input wire logic [7:0] TX_DATA_O,
	input wire logic TX_READY_I,
	input wire logic [4:0] LOW_PINS_GPIO_I,
	input wire uhp_desig_t PIN_DESIG_O,
	input wire logic [7:0] CURRENT_DIR_O,
	input wire uhp_misc_t MISC_O,
	input wire logic CMD_DONE_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic [5:0] rx_cnt; // Bytes taken in the current report, wraps at 64
	// Count taken command bytes so the 64th can be told apart
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			rx_cnt <= 6'h00;
		end else if (RX_VALID_I && RX_READY_O) begin
			rx_cnt <= rx_cnt + 6'h01;
		end
	end
	a_rx_stop_reply: assert property (RX_VALID_I && RX_READY_O && rx_cnt == 6'h3F |=>
		!RX_READY_O ##1 TX_VALID_O) else $error("reply not started after last byte");
	a_done_at_reply: assert property ($rose(TX_VALID_O) |-> CMD_DONE_O)
		else $error("done pulse missing at reply start");
	a_tx_held: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
		else $error("response byte dropped while stalled");
	a_one_way_only: assert property (TX_VALID_O |-> !RX_READY_O)
		else $error("command accepted during reply");
	a_desig_legal: assert property (PIN_DESIG_O.input_only_pin != 2'h1 && PIN_DESIG_O.general_pin_5 != 2'h3)
		else $error("illegal pin function stored");
	a_mode_legal: assert property (MISC_O.count_mode <= 3'h4)
		else $error("reserved counting mode stored");
	a_misc_on_done: assert property ($changed(MISC_O) |-> CMD_DONE_O)
		else $error("settings changed outside a command");
	a_dir_on_done: assert property ($changed(CURRENT_DIR_O) |-> CMD_DONE_O)
		else $error("direction changed outside a command");
	a_dir_gpio_only: assert property (((CURRENT_DIR_O[4:0] ^ $past(CURRENT_DIR_O[4:0]))
		& ~LOW_PINS_GPIO_I) == 5'h00) else $error("direction of a non-gpio pin changed");
endmodule : uhp_cmd_assertions

bind uhp_cmd uhp_cmd_assertions chk (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I),
	.RX_VALID_I(RX_VALID_I), .RX_READY_O(RX_READY_O), .TX_VALID_O(TX_VALID_O),
	.TX_DATA_O(TX_DATA_O), .TX_READY_I(TX_READY_I), .LOW_PINS_GPIO_I(LOW_PINS_GPIO_I),
	.PIN_DESIG_O(PIN_DESIG_O), .CURRENT_DIR_O(CURRENT_DIR_O), .MISC_O(MISC_O),
	.CMD_DONE_O(CMD_DONE_O));

// ### verification/uhp_host.sv
module uhp_host (
	input wire logic clk_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	input wire logic rx_ready_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] req [64]; // Outgoing command report
	logic [7:0] rsp [64]; // Collected response report
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b0;
	end
	// Reserved and trailing bytes go out as zero
	task clear_req();
		for (int i = 0; i < 64; i++) req[i] = 8'h00;
	endtask : clear_req
	// Ready is read a step after the edge, so it is the value the next edge samples
	task run(input logic stall);
		int i;
		int g;
		logic ok;
		i = 0;
		g = 0;
		@(posedge clk_i);
		#1;
		// A device that never answers is caught by the bench's cycle ceiling
		while (i < 64) begin
			rx_valid_o = 1'b1;
			rx_data_o = req[i];
			ok = rx_ready_i;
			@(posedge clk_i);
			#1;
			g++;
			if (ok) i++;
		end
		rx_valid_o = 1'b0;
		rx_data_o = ~req[63]; // Released line shows no stale byte
		i = 0;
		while (i < 64) begin
			tx_ready_o = !(stall && g[0]); // Slow host stalls every other cycle
			ok = tx_valid_i && tx_ready_o;
			rsp[i] = tx_data_i;
			@(posedge clk_i);
			#1;
			g++;
			if (ok) i++;
		end
		tx_ready_o = 1'b0;
	endtask : run
endmodule : uhp_host

// ### verification/uhp_cmd_bench.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module uhp_cmd_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, done;
	logic [7:0] rx_data, tx_data, desig, dout, ddir, cdir, exp_dir, mask;
	logic [4:0] low_gpio, misc;
	int n_errors, cmp_count, cycles;
	// Core clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	uhp_cmd dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
		.RX_READY_O(rx_ready), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_READY_I(tx_ready),
		.LOW_PINS_GPIO_I(low_gpio), .PIN_DESIG_O(desig), .DEFAULT_OUT_O(dout),
		.DEFAULT_DIR_O(ddir), .CURRENT_DIR_O(cdir), .MISC_O(misc), .CMD_DONE_O(done));
	uhp_host host (.clk_i(clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
	task close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end
	// Settings command; pins 6 and 7 and the output/direction bytes stay fixed
	task cfg(input logic [7:0] p5, input logic [7:0] p8, input logic [7:0] other);
		host.clear_req();
		host.req[0] = 8'h21;
		host.req[9] = p5;
		host.req[10] = 8'h02;
		host.req[12] = p8;
		host.req[13] = 8'hA5;
		host.req[14] = 8'h5A;
		host.req[15] = 8'h3C;
		host.req[16] = 8'h01;
		host.req[17] = other;
		host.run(1'b0);
		`CHK(host.rsp[0], 8'h21)
		`CHK(host.rsp[1], 8'h00)
	endtask : cfg
	// Direction get/set or other code, answered to a stalling host
	task dir_cmd(input logic [7:0] code, input logic [7:0] lo, input logic [7:0] hi);
		host.clear_req();
		host.req[0] = code;
		host.req[4] = lo;
		host.req[5] = hi;
		host.run(1'b1);
		`CHK(host.rsp[0], code)
	endtask : dir_cmd
	initial begin
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		rst_n = 1'b0;
		low_gpio = 5'h15;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK(misc, 5'h00)
		`CHK(cdir, 8'hFF)
		cfg(8'h01, 8'h02, 8'hF7);
		`CHK(desig, 8'h26)
		`CHK(dout, 8'hA5)
		`CHK(ddir, 8'h3C)
		`CHK(misc, 5'h17)
		// Pin 7 plus the low GPIO pins follow direction writes
		mask = {3'b100, low_gpio};
		exp_dir = (8'hFF & ~mask) | (8'h3C & mask);
		`CHK(cdir, exp_dir)
		// Every counting code; out-of-range functions leave pins as they were
		for (int m = 0; m < 8; m++) begin
			cfg(8'h03, 8'h01, {4'h0, m[2:0], 1'b0});
			`CHK(desig, 8'h26)
			`CHK(misc, {1'b0, (m < 5) ? m[2:0] : 3'h4, 1'b0})
		end
		dir_cmd(8'h33, 8'h00, 8'h00);
		`CHK(host.rsp[1], 8'h00)
		`CHK(host.rsp[4], exp_dir)
		`CHK(host.rsp[5], 8'h01)
		dir_cmd(8'h32, 8'h00, 8'h01);
		`CHK(host.rsp[1], 8'h00)
		exp_dir = exp_dir & ~mask;
		`CHK(cdir, exp_dir)
		dir_cmd(8'h33, 8'h00, 8'h00);
		`CHK(host.rsp[4], exp_dir)
		dir_cmd(8'h30, 8'hFF, 8'h01);
		`CHK(host.rsp[1], 8'hF8)
		`CHK(cdir, exp_dir)
		// Reset in mid-run brings every setting back to its reset value
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK(desig, 8'h00)
		`CHK(dout, 8'h00)
		`CHK(ddir, 8'hFF)
		`CHK(misc, 5'h00)
		`CHK(cdir, 8'hFF)
		dir_cmd(8'h33, 8'h00, 8'h00);
		`CHK(host.rsp[4], 8'hFF)
		close_out();
	end
endmodule : uhp_cmd_bench
